// *** hw/sfc_pkg.sv ***
// Package for the serial flash status and read instruction decoder
`default_nettype none
package sfc_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
  localparam logic [7:0] OP_READ_STATUS2 = 8'h35;
  localparam logic [7:0] OP_READ_STATUS3 = 8'h15;
  localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_WRITE_STATUS3 = 8'h11;
  localparam logic [7:0] OP_READ_DATA = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;

  // Frame geometry in serial clocks
  localparam logic [4:0] CNT_OPCODE_LAST = 5'h07;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
  localparam logic [4:0] CNT_DUMMY_LAST = 5'h07;
  localparam logic [4:0] CNT_ONE_BYTE = 5'h08;
  localparam logic [4:0] CNT_TWO_BYTES = 5'h10;

  // Status byte selectors
  localparam logic [1:0] SEL_SR1 = 2'h0;
  localparam logic [1:0] SEL_SR2 = 2'h1;
  localparam logic [1:0] SEL_SR3 = 2'h2;

  // Writable positions per byte; the rest stays read-only
  localparam logic [7:0] SR1_WR_MASK = 8'hFC;
  localparam logic [7:0] SR2_WR_MASK = 8'h7B;
  localparam logic [7:0] SR3_WR_MASK = 8'hE3;
  // security_lock_bits, protect_mode_bit_high, quad_enable_bit in byte two
  localparam logic [7:0] SR2_LOCK_MASK = 8'h38;
  localparam logic [7:0] SR2_PROTECT_HIGH_MASK = 8'h01;
  localparam logic [7:0] SR2_QUAD_ENABLE_MASK = 8'h02;

  // Power-up non-volatile contents
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STATUS_WRITE_CYCLE_TIME_NS = 5000000;
  localparam int VOLATILE_REFRESH_TIME_NS = 50;
  // Longest time rounds down, never below one cycle
  localparam int VOLATILE_REFRESH_CYCLES =
    (VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS);
  localparam logic [23:0] REFRESH_CYC = 24'(VOLATILE_REFRESH_CYCLES);

  // Synchroniser pin slots
  localparam int PIN_CS_N = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_RESET_N = 3;
  localparam int PIN_COUNT = 4;

  // Frame states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPCODE = 8'h02,
    ST_ADDR = 8'h04,
    ST_DUMMY = 8'h08,
    ST_RDATA = 8'h10,
    ST_SRD = 8'h20,
    ST_SWR = 8'h40,
    ST_IGNORE = 8'h80
  } sfc_state_type;

  // Working or non-volatile status bytes
  typedef struct packed {
    logic [7:0] sr3;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } sfc_status_type;

  // Array fetch request
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } sfc_fetch_type;

endpackage
`default_nettype wire

// *** hw/sfc_flash_cmd.sv ***
// Serial flash instruction decoder with read prefetch FIFO
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Prefetch buffer between array and serialiser
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Flags come from the count register so full and empty are honest
  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage, written by index
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // sfc_fifo

////////////////////////////////////////////////////////////////////////
// Top: serial frame decoder, status registers, array read streaming
module sfc_flash_cmd #(
  parameter int STATUS_WRITE_CYCLES =
    (sfc_pkg::STATUS_WRITE_CYCLE_TIME_NS + sfc_pkg::CLK_PERIOD_NS - 1)
    / sfc_pkg::CLK_PERIOD_NS,
  parameter int FIFO_DEPTH = 8
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Serial pins from the host
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic serial_input,
  input wire logic reset_pin_n,
  // Serial output pin
  output logic spi_do,
  output logic spi_do_oe,
  // Mode input
  input wire logic four_line_command_mode,
  // Array read port
  output sfc_pkg::sfc_fetch_type arr_fetch,
  input wire logic arr_rvalid,
  input wire logic [7:0] arr_rdata,
  // Status view
  output sfc_pkg::sfc_status_type status_now,
  output logic write_enable_latch,
  output logic status_busy
);
  import sfc_pkg::*;

  localparam logic [23:0] TW_CYC = 24'(STATUS_WRITE_CYCLES);

  logic [PIN_COUNT-1:0] sync1;
  logic [PIN_COUNT-1:0] sync2;
  logic sclk_d;
  logic cs_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic di_s;
  sfc_state_type state;
  logic [4:0] bit_cnt;
  logic [23:0] in_sh;
  logic [7:0] opcode;
  logic [7:0] opc_now;
  logic [1:0] sel;
  logic fast;
  logic vol_qual;
  logic reset_armed;
  logic refresh_on;
  logic [23:0] timer;
  sfc_status_type nv;
  sfc_status_type pend;
  sfc_status_type next_status;
  logic swr_ok;
  logic [7:0] status_byte;
  logic [2:0] out_cnt;
  logic [6:0] out_sh;
  logic fetch_on;
  logic fetch_wait;
  logic [23:0] fetch_addr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic fifo_flush;
  logic start_read;

  //////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin input
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          // Idle levels: clock low, rest high, so no false edge follows
          sync1[gi] <= (gi == PIN_SCLK) ? 1'b0 : 1'b1;
          sync2[gi] <= (gi == PIN_SCLK) ? 1'b0 : 1'b1;
        end else begin
          sync1[gi] <= (gi == PIN_CS_N) ? spi_cs_n :
                       (gi == PIN_SCLK) ? spi_clk :
                       (gi == PIN_DI) ? serial_input : reset_pin_n;
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // Edge history on the synchronised copies only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sync2[PIN_SCLK];
      cs_d <= sync2[PIN_CS_N];
    end
  end

  assign sclk_rise = sync2[PIN_SCLK] & ~sclk_d;
  assign sclk_fall = ~sync2[PIN_SCLK] & sclk_d;
  assign cs_rise = sync2[PIN_CS_N] & ~cs_d;
  assign di_s = sync2[PIN_DI];
  assign opc_now = {in_sh[6:0], di_s};

  //////////////////////////////////////////////////////////////////////
  // Frame state machine, input shifting on rising serial edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst || sync2[PIN_CS_N] || !sync2[PIN_RESET_N]) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_OPCODE;
          bit_cnt <= '0;
        end
        ST_OPCODE: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == CNT_OPCODE_LAST) begin
              bit_cnt <= '0;
              case (opc_now)
                OP_READ_STATUS1, OP_READ_STATUS2,
                OP_READ_STATUS3: state <= ST_SRD;
                OP_READ_DATA: state <= (status_busy ||
                  four_line_command_mode) ? ST_IGNORE : ST_ADDR;
                OP_FAST_READ: state <= status_busy ? ST_IGNORE : ST_ADDR;
                OP_WRITE_STATUS1, OP_WRITE_STATUS2,
                OP_WRITE_STATUS3: state <= ST_SWR;
                default: state <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == CNT_ADDR_LAST) begin
              bit_cnt <= '0;
              state <= fast ? ST_DUMMY : ST_RDATA;
            end
          end
        end
        ST_DUMMY: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == CNT_DUMMY_LAST) begin
              bit_cnt <= '0;
              state <= ST_RDATA;
            end
          end
        end
        ST_SWR, ST_IGNORE: begin
          // Count saturates so a long frame cannot alias a short one
          if (sclk_rise && bit_cnt != '1) begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        ST_RDATA, ST_SRD: state <= state;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Serial input shifter and latched opcode fields
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_sh <= '0;
      opcode <= '0;
      sel <= SEL_SR1;
      fast <= 1'b0;
    end else if (sclk_rise && !sync2[PIN_CS_N]) begin
      in_sh <= {in_sh[22:0], di_s};
      if (state == ST_OPCODE && bit_cnt == CNT_OPCODE_LAST) begin
        opcode <= opc_now;
        fast <= (opc_now == OP_FAST_READ);
        sel <= (opc_now == OP_READ_STATUS2 || opc_now == OP_WRITE_STATUS2) ?
               SEL_SR2 :
               (opc_now == OP_READ_STATUS3 || opc_now == OP_WRITE_STATUS3) ?
               SEL_SR3 : SEL_SR1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Masked status byte update shared by volatile and non-volatile writes
  function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] data, input logic [7:0] wmask,
      input logic [7:0] sticky, input logic [7:0] frozen);
    logic [7:0] r;
    r = (old & ~wmask) | (data & wmask);
    r = r | (old & sticky);
    r = (r & ~frozen) | (old & frozen);
    return r;
  endfunction

  // Candidate status after the write frame now ending
  always_comb begin
    sfc_status_type base;
    logic [7:0] sticky2;
    logic [7:0] frozen2;
    base = vol_qual ? status_now : nv;
    sticky2 = SR2_LOCK_MASK | (vol_qual ? SR2_PROTECT_HIGH_MASK : 8'h00);
    frozen2 = four_line_command_mode ? SR2_QUAD_ENABLE_MASK : 8'h00;
    next_status = base;
    swr_ok = 1'b0;
    if (bit_cnt == CNT_ONE_BYTE) begin
      swr_ok = 1'b1;
      case (sel)
        SEL_SR1: next_status.sr1 = merge(base.sr1, in_sh[7:0],
                                         SR1_WR_MASK, 8'h00, 8'h00);
        SEL_SR2: next_status.sr2 = merge(base.sr2, in_sh[7:0],
                                         SR2_WR_MASK, sticky2, frozen2);
        default: next_status.sr3 = merge(base.sr3, in_sh[7:0],
                                         SR3_WR_MASK, 8'h00, 8'h00);
      endcase
    end else if (bit_cnt == CNT_TWO_BYTES && sel == SEL_SR1) begin
      swr_ok = 1'b1;
      next_status.sr1 = merge(base.sr1, in_sh[15:8],
                              SR1_WR_MASK, 8'h00, 8'h00);
      next_status.sr2 = merge(base.sr2, in_sh[7:0],
                              SR2_WR_MASK, sticky2, frozen2);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Latch, qualifiers, status storage and the self-timed write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nv <= '{sr3: SR3_RESET, sr2: SR2_RESET, sr1: SR1_RESET};
      status_now <= '{sr3: SR3_RESET, sr2: SR2_RESET, sr1: SR1_RESET};
      pend <= '0;
      write_enable_latch <= 1'b0;
      status_busy <= 1'b0;
      vol_qual <= 1'b0;
      reset_armed <= 1'b0;
      refresh_on <= 1'b0;
      timer <= '0;
    end else if (!sync2[PIN_RESET_N]) begin
      // A reset abandons a write in flight; nothing is committed
      status_now <= nv;
      write_enable_latch <= 1'b0;
      status_busy <= 1'b0;
      vol_qual <= 1'b0;
      reset_armed <= 1'b0;
      refresh_on <= 1'b0;
    end else if (status_busy) begin
      // Only status reads run now; other frames are dropped
      timer <= timer - 1'b1;
      if (timer == 24'h000001) begin
        nv <= pend;
        status_now <= pend;
        status_busy <= 1'b0;
        write_enable_latch <= 1'b0;
      end
    end else begin
      if (refresh_on) begin
        timer <= timer - 1'b1;
        if (timer == 24'h000001) begin
          refresh_on <= 1'b0;
          status_now <= pend;
        end
      end
      if (cs_rise && state != ST_IDLE) begin
        vol_qual <= 1'b0;
        reset_armed <= 1'b0;
        if (state == ST_IGNORE && bit_cnt == '0) begin
          case (opcode)
            OP_WRITE_DISABLE: write_enable_latch <= 1'b0;
            OP_WRITE_ENABLE: write_enable_latch <= 1'b1;
            OP_VOL_WRITE_ENABLE: vol_qual <= 1'b1;
            OP_RESET_ENABLE: reset_armed <= 1'b1;
            OP_RESET_DEVICE: begin
              if (reset_armed) begin
                status_now <= nv;
                write_enable_latch <= 1'b0;
                refresh_on <= 1'b0;
              end
            end
            default: vol_qual <= 1'b0;
          endcase
        end else if (state == ST_SWR && swr_ok) begin
          pend <= next_status;
          if (vol_qual) begin
            refresh_on <= 1'b1;
            timer <= REFRESH_CYC;
          end else if (write_enable_latch) begin
            status_busy <= 1'b1;
            timer <= TW_CYC;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Byte presented for a status read, sampled afresh every byte
  always_comb begin
    case (sel)
      SEL_SR1: status_byte = {status_now.sr1[7:2], write_enable_latch,
                              status_busy};
      SEL_SR2: status_byte = status_now.sr2;
      default: status_byte = status_now.sr3;
    endcase
  end

  // Output serialiser on falling serial edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (state != ST_SRD && state != ST_RDATA)) begin
      spi_do <= 1'b0;
      spi_do_oe <= 1'b0;
      out_cnt <= '0;
      out_sh <= '0;
    end else if (sclk_fall) begin
      spi_do_oe <= 1'b1;
      out_cnt <= out_cnt + 1'b1;
      if (out_cnt == '0) begin
        // Status polls see live busy at each byte boundary
        if (state == ST_SRD) begin
          spi_do <= status_byte[7];
          out_sh <= status_byte[6:0];
        end else begin
          // An empty buffer only occurs with an out-of-spec clock
          spi_do <= fifo_out_valid ? fifo_out_data[7] : 1'b1;
          out_sh <= fifo_out_valid ? fifo_out_data[6:0] : 7'h7F;
        end
      end else begin
        spi_do <= out_sh[6];
        out_sh <= {out_sh[5:0], 1'b0};
      end
    end
  end

  assign fifo_pop = sclk_fall && state == ST_RDATA && out_cnt == '0;
  assign start_read = sclk_rise && state == ST_ADDR &&
                      bit_cnt == CNT_ADDR_LAST && !sync2[PIN_CS_N];
  assign fifo_flush = start_read;

  //////////////////////////////////////////////////////////////////////
  // Array fetch: one request outstanding, stalled by a full buffer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fetch_on <= 1'b0;
      fetch_wait <= 1'b0;
      fetch_addr <= '0;
      arr_fetch <= '0;
    end else begin
      arr_fetch.valid <= 1'b0;
      if (arr_rvalid) begin
        fetch_wait <= 1'b0;
        fetch_addr <= fetch_addr + 1'b1;
      end
      if (start_read) begin
        fetch_on <= 1'b1;
        fetch_addr <= {in_sh[22:0], di_s};
      end else if (state != ST_ADDR && state != ST_DUMMY &&
                   state != ST_RDATA) begin
        fetch_on <= 1'b0;
      end
      if (fetch_on && !fetch_wait && !arr_fetch.valid && fifo_in_ready &&
          !start_read) begin
        arr_fetch.valid <= 1'b1;
        arr_fetch.addr <= fetch_addr;
        fetch_wait <= 1'b1;
      end
    end
  end

  sfc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(fifo_flush),
    .in_valid(arr_rvalid & fetch_on),
    .in_ready(fifo_in_ready),
    .in_data(arr_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
endmodule // sfc_flash_cmd
`default_nettype wire

// *** tb/sfc_flash_cmd_sva.sv ***
// Port checker for the serial flash decoder
`timescale 1ns/10ps
`default_nettype none
module sfc_flash_cmd_sva #(
  parameter int STATUS_WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Serial side
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic reset_pin_n,
  input wire logic spi_do,
  input wire logic spi_do_oe,
  // Mode, array and status
  input wire logic four_line_command_mode,
  input wire sfc_pkg::sfc_fetch_type arr_fetch,
  input wire sfc_pkg::sfc_status_type status_now,
  input wire logic write_enable_latch,
  input wire logic status_busy
);
  import sfc_pkg::*;
  logic [31:0] busy_len;
  // Length of the current busy stretch
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !status_busy) begin
      busy_len <= 32'h0;
    end else begin
      busy_len <= busy_len + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // A write that ended by itself, not by the reset pin
  sequence s_write_end;
    $fell(status_busy) && reset_pin_n && $past(reset_pin_n, 4);
  endsequence
  sequence s_cs_idle;
    spi_cs_n [*8];
  endsequence
  property p_busy_len;
    s_write_end |-> busy_len == STATUS_WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy stretch has wrong length");
  property p_busy_wel;
    s_write_end |-> !write_enable_latch;
  endproperty
  a_busy_wel: assert property (p_busy_wel)
    else $error("latch still set after write");
  property p_lock;
    reset_pin_n && $past(reset_pin_n, 4) |->
      (~status_now.sr2[5:3] & $past(status_now.sr2[5:3])) == 3'h0;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit went back to zero");
  property p_fetch_busy;
    status_busy |-> !arr_fetch.valid;
  endproperty
  a_fetch_busy: assert property (p_fetch_busy)
    else $error("array fetch while busy");
  property p_fetch_quad;
    four_line_command_mode |-> !arr_fetch.valid;
  endproperty
  a_fetch_quad: assert property (p_fetch_quad)
    else $error("array fetch in four-line mode");
  property p_qe_frozen;
    four_line_command_mode && $past(four_line_command_mode) && reset_pin_n
      |-> $stable(status_now.sr2[1]);
  endproperty
  a_qe_frozen: assert property (p_qe_frozen)
    else $error("quad enable changed in four-line mode");
  property p_do_edge;
    spi_do_oe && $past(spi_do_oe) && $changed(spi_do) |-> !spi_clk;
  endproperty
  a_do_edge: assert property (p_do_edge)
    else $error("output moved outside the low clock phase");
  property p_oe_idle;
    s_cs_idle |-> !spi_do_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven with chip select high");
endmodule // sfc_flash_cmd_sva
`default_nettype wire

// *** tb/sfc_host_model.sv ***
// Host controller model driving the serial pins, mode 0
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic spi_cs_n,
  output logic spi_clk,
  output logic serial_input,
  input wire logic miso
);
  logic [63:0] rx;
  // Idle pins: deselected, clock low
  initial begin
    spi_cs_n = 1'b1;
    spi_clk = 1'b0;
    serial_input = 1'b0;
    rx = 64'h0;
  end
  // Half of the 160 ns link period
  task automatic half();
    repeat (10) @(posedge clk_sys);
  endtask
  // One framed transfer, MSB first, data taken on rising edges
  task automatic frame(input logic [63:0] tx, input int n);
    rx = 64'h0;
    spi_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_input <= tx[i];
      half();
      spi_clk <= 1'b1;
      rx = {rx[62:0], miso};
      half();
      spi_clk <= 1'b0;
    end
    half();
    // Opcode and bit count together fix the instruction at chip select rise
    spi_cs_n <= 1'b1;
    serial_input <= ~serial_input; // Released line shows no stale bit
    repeat (12) @(posedge clk_sys); // Gap outlasts the volatile refresh
  endtask
endmodule // sfc_host_model
`default_nettype wire

// *** tb/tb.sv ***
// Bench for the serial flash decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sfc_pkg::*;
  localparam int WC = 2000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic four_line_command_mode = 1'b0;
  logic arr_rvalid = 1'b0;
  logic [7:0] arr_rdata = 8'h00;
  logic [63:0] rx;
  sfc_fetch_type arr_fetch;
  sfc_status_type status_now;
  wire logic spi_cs_n, spi_clk, serial_input, miso;
  wire logic spi_do, spi_do_oe, write_enable_latch, status_busy;
  int fails = 0;
  int samples_checked = 0;
  int fetches = 0;
  // Clock; the output line has a pull-up when released
  always #4 clk_sys = ~clk_sys;
  assign miso = spi_do_oe ? spi_do : 1'b1;
  sfc_flash_cmd #(.STATUS_WRITE_CYCLES(WC), .FIFO_DEPTH(8)) sfc_flash_cmd_i (
    .clk_sys, .sys_rst, .spi_cs_n, .spi_clk, .serial_input, .reset_pin_n,
    .spi_do, .spi_do_oe, .four_line_command_mode, .arr_fetch, .arr_rvalid,
    .arr_rdata, .status_now, .write_enable_latch, .status_busy);
  sfc_host_model sfc_host_model_i (.clk_sys, .spi_cs_n, .spi_clk,
    .serial_input, .miso);
  // Array answers a cycle later; byte is address low byte xor 5A
  always @(posedge clk_sys) begin
    arr_rvalid <= arr_fetch.valid;
    arr_rdata <= arr_fetch.addr[7:0] ^ 8'h5A;
    if (arr_fetch.valid === 1'b1) fetches++;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] m(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  // Latch and busy positions are not stored bits
  function automatic logic [23:0] sv();
    return status_now & 24'hFFFFFC;
  endfunction
  task automatic xf(input logic [63:0] tx, input int n);
    sfc_host_model_i.frame(tx, n);
    rx = sfc_host_model_i.rx;
  endtask
  // Two repeats of one status byte
  task automatic rd_sr(input logic [7:0] code, input logic [7:0] b);
    xf({code, 16'h0}, 24);
    check(rx[15:0], {b, b});
  endtask
  // Poll busy with status reads only
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xf({OP_READ_STATUS1, 8'h00}, 16);
      n++;
    end while (rx[0] !== 1'b0 && n < 30);
    check(rx[0], 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    xf(OP_WRITE_ENABLE, 8);
    check(write_enable_latch, 1'b1);
    rd_sr(OP_READ_STATUS1, 8'h02);
    xf(OP_WRITE_DISABLE, 8);
    check(write_enable_latch, 1'b0);
    xf(OP_VOL_WRITE_ENABLE, 8);
    check(write_enable_latch, 1'b0);
    rd_sr(OP_READ_STATUS2, 8'h00);
    xf({OP_WRITE_STATUS2, 8'h40}, 16);
    check(sv(), 24'h0);
  endtask
  task automatic t_nv();
    int f0;
    xf({OP_WRITE_STATUS1, 8'hA4}, 16);
    check({status_busy, sv()}, {1'b0, 24'h0});
    xf(OP_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS1, 8'hA7, 8'hC6}, 24);
    rd_sr(OP_READ_STATUS1, 8'h03);
    f0 = fetches;
    xf({OP_READ_DATA, 24'h000010, 8'h00}, 40);
    check({fetches, rx[7:0]}, {f0, 8'hFF});
    wait_idle();
    check(sv(), 24'h0042A4);
    check(write_enable_latch, 1'b0);
    xf(OP_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS1, 8'h00}, 16);
    wait_idle();
    check(sv(), 24'h004200);
  endtask
  task automatic t_vol();
    xf(OP_VOL_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS2, 8'h09}, 16);
    check(status_busy, 1'b0);
    rd_sr(OP_READ_STATUS2, 8'h09);
    xf(OP_VOL_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS2, 8'h00}, 16);
    rd_sr(OP_READ_STATUS2, 8'h09);
    xf(OP_VOL_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS3, 8'hFF}, 16);
    rd_sr(OP_READ_STATUS3, 8'hE3);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(sv(), 24'h004200);
    // Software reset needs its arming frame right before it
    xf(OP_VOL_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS3, 8'hFF}, 16);
    xf(OP_WRITE_ENABLE, 8);
    xf(OP_RESET_ENABLE, 8);
    xf(OP_RESET_DEVICE, 8);
    check({write_enable_latch, sv()}, {1'b0, 24'h004200});
  endtask
  task automatic t_read();
    int f0;
    xf({OP_READ_DATA, 24'h0000FE, 24'h0}, 56);
    check(rx[23:0], {m(8'hFE), m(8'hFF), m(8'h00)});
    xf({OP_FAST_READ, 24'h123456, 32'h0}, 64);
    check(rx[23:0], {m(8'h56), m(8'h57), m(8'h58)});
    four_line_command_mode <= 1'b1;
    f0 = fetches;
    xf({OP_READ_DATA, 24'h0, 8'h0}, 40);
    check(fetches, f0);
    xf(OP_VOL_WRITE_ENABLE, 8);
    xf({OP_WRITE_STATUS2, 8'h00}, 16);
    rd_sr(OP_READ_STATUS2, 8'h02);
    four_line_command_mode <= 1'b0;
  endtask
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_latch();
    t_nv();
    t_vol();
    t_read();
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
endmodule // tb
bind sfc_flash_cmd sfc_flash_cmd_sva #(
  .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) sfc_flash_cmd_sva_i (
  .clk_sys, .sys_rst, .spi_cs_n, .spi_clk, .reset_pin_n, .spi_do,
  .spi_do_oe, .four_line_command_mode, .arr_fetch, .status_now,
  .write_enable_latch, .status_busy);
`default_nettype wire
